//--- core/esr_core.sv
// endpoint-zero standard request handling with address and frame tracking
`timescale 1ns/1ps
`include "esr_map.svh"

// Contract
// - configuration changes leave endpoint state untouched
// - status stage held until handshake bit released
// - answer only address zero until assigned
// - core copies set-address into function address
// - address holds until bus reset, detach or soft re-enumeration
// - function address readable, CPU writes ignored
// - soft re-enumeration clears function address
// - core exposes current frame number registers
// - frame number eleven bits, wraps at 2048
// - request class from type bits six:five
module esr_core (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    // usb side
    input  wire logic                   setup_valid,
    input  wire logic [63:0]            setup_bytes,
    input  wire logic                   status_token,
    input  wire logic                   status_ok,
    input  wire logic                   sof_valid,
    input  wire logic [10:0]            sof_frame,
    input  wire logic                   bus_reset,
    input  wire logic                   detach,
    input  wire logic [6:0]             token_addr,
    input  wire logic                   token_valid,
    output logic                        token_match,
    output logic                        status_ack,
    output logic                        status_nak,
    output logic [6:0]                  function_address_register,
    output logic                        is_vendor_req,
    // cpu side
    input  wire logic [5:0]             cpu_addr,
    input  wire logic [7:0]             cpu_wdata,
    input  wire logic                   cpu_wr,
    input  wire logic                   cpu_rd,
    output logic [7:0]                  cpu_rdata,
    output logic                        irq
);

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    function automatic esr_pkg::esr_class_t req_class(input logic [7:0] t);
        req_class = esr_pkg::esr_class_t'(t[6:5]);
    endfunction

    function automatic logic [7:0] sbyte(input logic [63:0] s,
                                         input logic [2:0] i);
        sbyte = s[{i, 3'h0} +: 8];
    endfunction

    esr_pkg::esr_state_t st_q;
    logic [63:0]         setup_q;
    logic                hs_nak_q;
    logic [6:0]          pend_addr_q;
    logic                pend_addr_v_q;
    logic [10:0]         frame_q;
    logic [7:0]          inbc_q;
    logic [7:0]          inbuf_q [0:31];
    logic [`ESR_IRQ_W-1:0] stat_q;
    logic [`ESR_IRQ_W-1:0] mask_q;
    logic                soft_reenum;
    logic                release_wr;
    logic                is_std;
    logic [7:0]          req_code;

    assign is_std      = req_class(sbyte(setup_bytes, 3'h0))
                         == esr_pkg::ESR_CLS_STD;
    assign req_code    = sbyte(setup_bytes, 3'h1);
    assign release_wr  = cpu_wr && cpu_addr == `ESR_OFF_EP0CS
                         && cpu_wdata[`ESR_BIT_HS_NAK];
    assign soft_reenum = cpu_wr && cpu_addr == `ESR_OFF_REENUM
                         && cpu_wdata[0];

    // ------------------------------------------------------------
    // control transfer sequencing
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q     <= esr_pkg::ESR_ST_IDLE;
            hs_nak_q <= 1'b0;
            setup_q  <= 64'h0;
        end else if (setup_valid) begin
            setup_q  <= setup_bytes;
            st_q     <= esr_pkg::ESR_ST_HOLD;
            hs_nak_q <= 1'b1;
        end else begin
            case (st_q)
                esr_pkg::ESR_ST_HOLD: begin
                    if (release_wr) begin
                        hs_nak_q <= 1'b0;
                        st_q    <= esr_pkg::ESR_ST_STATUS;
                    end
                end
                esr_pkg::ESR_ST_STATUS: begin
                    if (status_token && status_ok) begin
                        st_q <= esr_pkg::ESR_ST_IDLE;
                    end
                end
                default: st_q <= esr_pkg::ESR_ST_IDLE;
            endcase
        end
    end

    // status stage answer, one cycle per status token
    always_ff @(posedge mclk) begin
        if (srst) begin
            status_ack <= 1'b0;
            status_nak <= 1'b0;
        end else begin
            status_ack <= status_token
                          && st_q == esr_pkg::ESR_ST_STATUS;
            status_nak <= status_token
                          && st_q != esr_pkg::ESR_ST_STATUS;
        end
    end

    // ------------------------------------------------------------
    // function address: set only by the core; a cpu write can only clear it, through soft re-enumeration
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_addr_q   <= `ESR_RST_FUNC_ADDR;
            pend_addr_v_q <= 1'b0;
            function_address_register <= `ESR_RST_FUNC_ADDR;
        end else if (bus_reset || detach || soft_reenum) begin
            pend_addr_v_q <= 1'b0;
            function_address_register <= `ESR_RST_FUNC_ADDR;
        end else if (setup_valid) begin
            // address field is the low seven bits of setup byte 2
            pend_addr_q   <= setup_bytes[22:16];
            pend_addr_v_q <= is_std
                             && req_code == `ESR_REQ_SET_ADDR;
        end else if (pend_addr_v_q && status_token && status_ok
                     && st_q == esr_pkg::ESR_ST_STATUS) begin
            // takes effect after status stage completes at old address
            function_address_register <= pend_addr_q;
            pend_addr_v_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            token_match   <= 1'b0;
            is_vendor_req <= 1'b0;
        end else begin
            token_match   <= token_valid
                             && token_addr == function_address_register;
            if (setup_valid) begin
                is_vendor_req <= req_class(sbyte(setup_bytes, 3'h0))
                                 == esr_pkg::ESR_CLS_VENDOR;
            end
        end
    end

    // ------------------------------------------------------------
    // frame number, eleven bits from each start of frame
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            frame_q <= 11'h000;
        end else if (sof_valid) begin
            frame_q <= sof_frame;
        end
    end

    // ------------------------------------------------------------
    // ep zero in buffer and byte count written by firmware
    // configuration requests change no endpoint state here
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            inbc_q <= 8'h00;
        end else if (cpu_wr && cpu_addr == `ESR_OFF_INBC) begin
            inbc_q <= cpu_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (cpu_wr && cpu_addr >= `ESR_OFF_INBUF) begin
            inbuf_q[cpu_addr[4:0]] <= cpu_wdata;
        end
    end

    // ------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins
    // ------------------------------------------------------------
    logic [`ESR_IRQ_W-1:0] ev;
    logic [`ESR_IRQ_W-1:0] clr;
    assign ev[`ESR_BIT_SETUP_IRQ]  = setup_valid;
    assign ev[`ESR_BIT_SOF_IRQ]    = sof_valid;
    assign ev[`ESR_BIT_REENUM_IRQ] = bus_reset;
    assign ev[`ESR_BIT_CFG_IRQ]    = setup_valid && is_std
        && (req_code == `ESR_REQ_SET_CFG || req_code == `ESR_REQ_SET_IF);
    assign clr = (cpu_wr && cpu_addr == `ESR_OFF_IRQ_STAT)
                 ? cpu_wdata[`ESR_IRQ_W-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (srst) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr) | ev;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_q <= '0;
        end else if (cpu_wr && cpu_addr == `ESR_OFF_IRQ_MASK) begin
            mask_q <= cpu_wdata[`ESR_IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_q & ~clr) | ev) & mask_q);
        end
    end

    // ------------------------------------------------------------
    // cpu read port, data one cycle after strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            cpu_rdata <= 8'h00;
        end else if (!cpu_rd) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_addr <= `ESR_OFF_SETUP7) begin
            cpu_rdata <= sbyte(setup_q, cpu_addr[2:0]);
        end else if (cpu_addr == `ESR_OFF_EP0CS) begin
            cpu_rdata <= {6'h00, hs_nak_q, 1'b0};
        end else if (cpu_addr == `ESR_OFF_INBC) begin
            cpu_rdata <= inbc_q;
        end else if (cpu_addr == `ESR_OFF_FUNC_ADDR) begin
            cpu_rdata <= {1'b0, function_address_register};
        end else if (cpu_addr == `ESR_OFF_FRML) begin
            cpu_rdata <= frame_q[7:0];
        end else if (cpu_addr == `ESR_OFF_FRMH) begin
            cpu_rdata <= {5'h00, frame_q[10:8]};
        end else if (cpu_addr == `ESR_OFF_IRQ_STAT) begin
            cpu_rdata <= {4'h0, stat_q};
        end else if (cpu_addr == `ESR_OFF_IRQ_MASK) begin
            cpu_rdata <= {4'h0, mask_q};
        end else if (cpu_addr >= `ESR_OFF_INBUF) begin
            cpu_rdata <= inbuf_q[cpu_addr[4:0]];
        end else begin
            cpu_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    nak_until_release_a: assert property (
        st_q == esr_pkg::ESR_ST_HOLD && status_token |=> status_nak)
        else $error("status not nakked while held");
    release_clears_a: assert property (
        st_q == esr_pkg::ESR_ST_HOLD && release_wr && !setup_valid
        |=> !hs_nak_q && st_q == esr_pkg::ESR_ST_STATUS)
        else $error("release did not clear handshake bit");
    setup_sets_nak_a: assert property (
        setup_valid |=> hs_nak_q && stat_q[`ESR_BIT_SETUP_IRQ])
        else $error("setup did not raise event");
    addr_bus_reset_a: assert property (
        bus_reset |=> function_address_register == 7'h00)
        else $error("bus reset did not clear address");
    addr_reenum_a: assert property (
        soft_reenum |=> function_address_register == 7'h00)
        else $error("re-enumeration did not clear address");
    addr_cpu_wr_a: assert property (
        cpu_wr && cpu_addr == `ESR_OFF_FUNC_ADDR && !status_token
        && !bus_reset && !detach
        |=> $stable(function_address_register))
        else $error("cpu write changed function address");
    addr_stable_a: assert property (
        !bus_reset && !detach && !soft_reenum && !status_token
        |=> $stable(function_address_register))
        else $error("address changed without cause");
    frame_take_a: assert property (
        sof_valid |=> frame_q == $past(sof_frame))
        else $error("frame number not taken");
    addr_read_a: assert property (
        cpu_rd && cpu_addr == `ESR_OFF_FUNC_ADDR
        |=> cpu_rdata == {1'b0, $past(function_address_register)})
        else $error("function address read wrong");
    vendor_class_a: assert property (
        setup_valid |=> is_vendor_req == ($past(setup_bytes[6:5]) == 2'b10))
        else $error("vendor class wrong");

    setup_seen_c: cover property (setup_valid ##[1:60] release_wr);
    addr_set_c: cover property (pend_addr_v_q ##[1:80] status_ack);
    irq_c: cover property (irq);
endmodule // esr_core

//--- core/esr_map.svh
// register offsets, field positions, request codes and reset values
`ifndef ESR_MAP_SVH
`define ESR_MAP_SVH

`define ESR_ADDR_W          6
`define ESR_OFF_SETUP0      6'h00
`define ESR_OFF_SETUP7      6'h07
`define ESR_OFF_EP0CS       6'h08
`define ESR_OFF_INBC        6'h09
`define ESR_OFF_FUNC_ADDR   6'h0a
`define ESR_OFF_FRML        6'h0b
`define ESR_OFF_FRMH        6'h0c
`define ESR_OFF_IRQ_STAT    6'h0d
`define ESR_OFF_IRQ_MASK    6'h0e
`define ESR_OFF_REENUM      6'h0f
`define ESR_OFF_INBUF       6'h20
`define ESR_OFF_INBUF_END   6'h3f

`define ESR_BIT_HS_NAK      1
`define ESR_BIT_SETUP_IRQ   0
`define ESR_BIT_SOF_IRQ     1
`define ESR_BIT_REENUM_IRQ  2
`define ESR_BIT_CFG_IRQ     3
`define ESR_IRQ_W           4

`define ESR_FRAME_W         11
`define ESR_RTYPE_STD       2'b00
`define ESR_RTYPE_VENDOR    2'b10
`define ESR_REQ_SET_ADDR    8'h05
`define ESR_REQ_GET_CFG     8'h08
`define ESR_REQ_SET_CFG     8'h09
`define ESR_REQ_GET_IF      8'h0a
`define ESR_REQ_SET_IF      8'h0b
`define ESR_REQ_SYNC        8'h0c
`define ESR_RST_FUNC_ADDR   7'h00

`endif

//--- core/esr_pkg.sv
// types shared by the endpoint-zero request handler
package esr_pkg;
    typedef enum logic [1:0] {
        ESR_ST_IDLE   = 2'b00,
        ESR_ST_HOLD   = 2'b01,
        ESR_ST_STATUS = 2'b10
    } esr_state_t;

    typedef enum logic [1:0] {
        ESR_CLS_STD    = 2'b00,
        ESR_CLS_CLASS  = 2'b01,
        ESR_CLS_VENDOR = 2'b10,
        ESR_CLS_RSVD   = 2'b11
    } esr_class_t;
endpackage

//--- dv/esr_core_tb.sv
// self-checking bench for the endpoint-zero request handler
`timescale 1ns/1ps
`include "esr_map.svh"
module esr_core_tb;
    logic mclk = 1'b0, srst = 1'b1, bus_reset = 1'b0, detach = 1'b0;
    logic [5:0] cpu_addr = 6'h00;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata;
    logic cpu_wr = 1'b0, cpu_rd = 1'b0, irq, is_vendor_req;
    logic setup_valid, status_token, status_ok, sof_valid, token_valid;
    logic token_match, status_ack, status_nak;
    logic [63:0] setup_bytes, reqs [6];
    logic [10:0] sof_frame;
    logic [6:0] token_addr, fn_addr, fn_exp;
    int err_count = 0, check_count = 0;

    always #10 mclk = ~mclk;

    esr_host_model esr_host_model_inst (.mclk(mclk),
        .setup_valid(setup_valid), .setup_bytes(setup_bytes),
        .status_token(status_token), .status_ok(status_ok),
        .sof_valid(sof_valid), .sof_frame(sof_frame),
        .token_addr(token_addr), .token_valid(token_valid));
    esr_core esr_core_inst (.mclk(mclk), .srst(srst),
        .setup_valid(setup_valid), .setup_bytes(setup_bytes),
        .status_token(status_token), .status_ok(status_ok),
        .sof_valid(sof_valid), .sof_frame(sof_frame),
        .bus_reset(bus_reset), .detach(detach), .token_addr(token_addr),
        .token_valid(token_valid), .token_match(token_match),
        .status_ack(status_ack), .status_nak(status_nak),
        .function_address_register(fn_addr),
        .is_vendor_req(is_vendor_req), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .irq(irq));

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic check8(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check1(input string nm, input logic e, g);
        check8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic cpu_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_wr <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask
    task automatic reg_chk(input string nm, input logic [5:0] a,
                           input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge mclk);
        cpu_rd <= 1'b1;
        cpu_addr <= a;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        #1 check8(nm, e, cpu_rdata & m);
    endtask
    task automatic tok_chk(input logic [6:0] a, input logic e);
        esr_host_model_inst.token(a);
        #1 check1("token_match", e, token_match);
    endtask
    // full control transfer with firmware answering in ans
    task automatic ctrl(input logic [63:0] b, input logic [15:0] ans);
        logic [7:0] st;
        st = (b[6:5] == 2'b00 && (b[15:8] == `ESR_REQ_SET_CFG ||
              b[15:8] == `ESR_REQ_SET_IF)) ? 8'h09 : 8'h01;
        esr_host_model_inst.setup(b);
        #1 check1("vendor_class", b[6:5] == 2'b10, is_vendor_req);
        reg_chk("irq_status", `ESR_OFF_IRQ_STAT, st);
        check1("irq_level", 1'b1, irq);
        for (int i = 0; i < 8; i++)
            reg_chk("setup_byte", i[5:0], b[8*i +: 8]);
        reg_chk("hs_set", `ESR_OFF_EP0CS, 8'h02, 8'h02);
        esr_host_model_inst.status(0);
        #1 check1("status_nak", 1'b1, status_nak);
        check1("early_ack", 1'b0, status_ack);
        check8("addr_held", {1'b0, fn_exp}, {1'b0, fn_addr});
        if (b[7]) begin
            cpu_write(`ESR_OFF_INBUF, ans[7:0]);
            cpu_write(`ESR_OFF_INBUF + 6'h01, ans[15:8]);
            cpu_write(`ESR_OFF_INBC, b[55:48]);
        end
        if (b[15:0] == {`ESR_REQ_SET_IF, 8'h00}) begin
            cpu_write(`ESR_OFF_INBC, 8'h00);
            reg_chk("inbc_rearm", `ESR_OFF_INBC, 8'h00);
        end
        cpu_write(`ESR_OFF_EP0CS, 8'h02);
        reg_chk("hs_clear", `ESR_OFF_EP0CS, 8'h00, 8'h02);
        esr_host_model_inst.status(3);
        #1 check1("status_ack", 1'b1, status_ack);
        check1("late_nak", 1'b0, status_nak);
        if (b[15:0] == {`ESR_REQ_SET_ADDR, 8'h00})
            fn_exp = b[22:16];
        reg_chk("func_addr", `ESR_OFF_FUNC_ADDR, {1'b0, fn_exp});
        cpu_write(`ESR_OFF_IRQ_STAT, 8'h0f);
        reg_chk("irq_cleared", `ESR_OFF_IRQ_STAT, 8'h00);
        check1("irq_low", 1'b0, irq);
    endtask
    // kind 0 bus reset, 1 detach, 2 soft re-enumeration
    task automatic drop_addr(input int kind);
        if (kind == 2)
            cpu_write(`ESR_OFF_REENUM, 8'h01);
        else begin
            @(posedge mclk);
            {bus_reset, detach} <= kind ? 2'b01 : 2'b10;
            @(posedge mclk);
            {bus_reset, detach} <= 2'b00;
        end
        fn_exp = 7'h00;
        reg_chk("addr_dropped", `ESR_OFF_FUNC_ADDR, 8'h00);
        cpu_write(`ESR_OFF_IRQ_STAT, 8'h0f);
    endtask
    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end
    initial begin
        fn_exp = 7'h00;
        reqs = '{64'h0000_0000_0003_0900, 64'h0001_0000_0000_0880,
                 64'h0000_0001_0002_0b00, 64'h0001_0001_0000_0a81,
                 64'h0002_0088_0000_0c82, 64'h0010_0000_1234_a040};
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        reg_chk("func_addr_reset", `ESR_OFF_FUNC_ADDR, 8'h00);
        reg_chk("unmapped", 6'h10, 8'h00);
        cpu_write(`ESR_OFF_IRQ_MASK, 8'h0f);
        tok_chk(7'h00, 1'b1);
        tok_chk(7'h05, 1'b0);
        ctrl(64'h0000_0000_002a_0500, 16'h0000);
        tok_chk(7'h2a, 1'b1);
        tok_chk(7'h00, 1'b0);
        cpu_write(`ESR_OFF_FUNC_ADDR, 8'h11);
        reg_chk("func_addr_ro", `ESR_OFF_FUNC_ADDR, 8'h2a);
        esr_host_model_inst.sof(11'h7f5);
        reg_chk("frame_low", `ESR_OFF_FRML, 8'hf5);
        reg_chk("frame_high", `ESR_OFF_FRMH, 8'h07);
        cpu_write(`ESR_OFF_FRML, 8'h55);
        reg_chk("frame_ro", `ESR_OFF_FRML, 8'hf5);
        reg_chk("sof_status", `ESR_OFF_IRQ_STAT, 8'h02);
        cpu_write(`ESR_OFF_IRQ_STAT, 8'h02);
        for (int i = 0; i < 6; i++)
            ctrl(reqs[i], i == 4 ? {5'h00, 11'h7f5 + 11'd20} :
                 (i == 1 ? 16'h0003 : 16'h0002));
        cpu_write(`ESR_OFF_IRQ_MASK, 8'h00);
        esr_host_model_inst.sof(11'h000);
        reg_chk("masked_status", `ESR_OFF_IRQ_STAT, 8'h02);
        check1("irq_masked", 1'b0, irq);
        cpu_write(`ESR_OFF_IRQ_MASK, 8'h02);
        reg_chk("mask_rb", `ESR_OFF_IRQ_MASK, 8'h02);
        check1("irq_unmasked", 1'b1, irq);
        cpu_write(`ESR_OFF_IRQ_STAT, 8'h02);
        reg_chk("w1c", `ESR_OFF_IRQ_STAT, 8'h00);
        check1("irq_w1c", 1'b0, irq);
        cpu_write(`ESR_OFF_IRQ_MASK, 8'h0f);
        reg_chk("frame_wrap", `ESR_OFF_FRMH, 8'h00);
        drop_addr(0);
        ctrl(64'h0000_0000_0015_0500, 16'h0000);
        drop_addr(1);
        ctrl(64'h0000_0000_007f_0500, 16'h0000);
        tok_chk(7'h7f, 1'b1);
        drop_addr(2);
        tok_chk(7'h00, 1'b1);
        give_verdict();
    end
endmodule // esr_core_tb

//--- dv/esr_host_model.sv
// usb host model: setup, status, frame and token traffic
`timescale 1ns/1ps
module esr_host_model (
    input  wire logic mclk,
    output logic      setup_valid,
    output logic [63:0] setup_bytes,
    output logic      status_token,
    output logic      status_ok,
    output logic      sof_valid,
    output logic [10:0] sof_frame,
    output logic [6:0] token_addr,
    output logic      token_valid
);
    // ----------------------------------------
    // one-cycle requests; lines go stale after
    // ----------------------------------------
    initial begin
        {setup_valid, status_token, status_ok, sof_valid, token_valid} = '0;
        setup_bytes = '0;
        sof_frame = '0;
        token_addr = '0;
    end
    task automatic setup(input logic [63:0] b);
        @(posedge mclk);
        setup_valid <= 1'b1;
        setup_bytes <= b;
        @(posedge mclk);
        setup_valid <= 1'b0;
        setup_bytes <= ~b;
    endtask
    // gap models a slow host before the status token
    task automatic status(input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        status_token <= 1'b1;
        status_ok <= 1'b1;
        @(posedge mclk);
        status_token <= 1'b0;
        status_ok <= 1'b0;
    endtask
    task automatic sof(input logic [10:0] f);
        @(posedge mclk);
        sof_valid <= 1'b1;
        sof_frame <= f;
        @(posedge mclk);
        sof_valid <= 1'b0;
        sof_frame <= ~f;
    endtask
    task automatic token(input logic [6:0] a);
        @(posedge mclk);
        token_valid <= 1'b1;
        token_addr <= a;
        @(posedge mclk);
        token_valid <= 1'b0;
        token_addr <= ~a;
    endtask
endmodule // esr_host_model
